// ==== ovuc_top.sv ====
// output driver power, mute, gain and paired volume commit control
`default_nettype none
//
// Operation
// - headphone mute and gain -57 to +6 dB
// - update bit is write-only commit strobe
// - update 0 stores headphone value pending
// - update 1 commits both headphone channels
// - speaker pair uses same commit scheme
// - zero-cross enabled defers change until crossing
// - zero-cross disabled applies change at once
// - each driver has its own power enable
// - headphones fed only from main mixers
// - boost bits set after reset
// - boost multiplies speaker and aux gain 1.5
// - speaker normal or ultralow distortion mode
// - aux outputs own mute, gain, source
module ovuc_top
(
   // clock, reset, enable
   input  wire logic                i_clk,
   input  wire logic                i_sys_rst,
   input  wire logic                i_ce,
   // register port
   input  wire logic [6:0]          i_addr,
   input  wire logic [8:0]          i_wdata,
   input  wire logic                i_wr,
   input  wire logic                i_rd,
   output logic      [8:0]          o_rdata,
   // zero-crossing pulses from the analog channels (async)
   input  wire logic [3:0]          i_zero_cross,
   // output stage controls
   output ovuc_pkg::ovuc_drv_t      o_left_headphone_out,
   output ovuc_pkg::ovuc_drv_t      o_right_headphone_out,
   output ovuc_pkg::ovuc_drv_t      o_left_speaker_out,
   output ovuc_pkg::ovuc_drv_t      o_right_speaker_out,
   output ovuc_pkg::ovuc_drv_t      o_aux_output_one,
   output ovuc_pkg::ovuc_drv_t      o_aux_output_two,
   output logic      [1:0]          o_aux_one_source,
   output logic      [1:0]          o_aux_two_source,
   output logic                     o_speaker_bias_select,
   output logic                     o_speaker_low_distortion
);
   import ovuc_pkg::*;

   // volume channel index for an address; 4 means not a volume register
   function automatic logic [2:0] vol_index(input logic [6:0] a);
      logic [2:0] idx;
      idx = 3'd4;
      if (a == OVUC_ADDR_HP_L)
         idx = 3'd0;
      else if (a == OVUC_ADDR_HP_R)
         idx = 3'd1;
      else if (a == OVUC_ADDR_SPK_L)
         idx = 3'd2;
      else if (a == OVUC_ADDR_SPK_R)
         idx = 3'd3;
      return idx;
   endfunction

   // clamp a gain code into the documented range
   function automatic logic [5:0] clamp_gain(input logic [5:0] g);
      return (g > OVUC_GAIN_MAX) ? OVUC_GAIN_MAX : g;
   endfunction

   // ---- zero-cross synchronisers ----
   logic [3:0] zc_s1_r;
   logic [3:0] zc_s2_r;
   logic [3:0] zc_s3_r;
   logic [3:0] zc_edge;

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         zc_s1_r <= 4'h0;
         zc_s2_r <= 4'h0;
         zc_s3_r <= 4'h0;
      end
      else if (i_ce)
      begin
         zc_s1_r <= i_zero_cross;
         zc_s2_r <= zc_s1_r;
         zc_s3_r <= zc_s2_r;
      end
   end

   // third flop only serves the edge detector, never the first stage
   // crossing marks are counted on a rising edge of the synchronised level
   assign zc_edge = zc_s2_r & ~zc_s3_r;

   // ---- control registers ----
   logic [8:0] pwr_r,   pwr_nxt;
   logic [8:0] boost_r, boost_nxt;
   logic [8:0] mode_r,  mode_nxt;
   logic [8:0] aux1_r,  aux1_nxt;
   logic [8:0] aux2_r,  aux2_nxt;
   logic [8:0] rdata_r, rdata_nxt;

   // ---- per-channel volume state ----
   ovuc_vol_t pend_r   [OVUC_NCH];
   ovuc_vol_t pend_nxt [OVUC_NCH];
   ovuc_vol_t act_r    [OVUC_NCH];
   ovuc_vol_t act_nxt  [OVUC_NCH];
   logic [OVUC_NCH-1:0] wait_r, wait_nxt;   // commit armed, waiting for a crossing

   logic [2:0] widx;
   logic       commit_pair;
   logic [OVUC_NCH-1:0] commit;

   always_comb
   begin
      widx        = vol_index(i_addr);
      commit_pair = 1'b0;
      if (i_wr && widx != 3'd4)
         commit_pair = i_wdata[OVUC_BIT_UPDATE];
      commit = 4'h0;
      if (commit_pair && widx[1] == 1'b0)
         commit[1:0] = 2'b11;
      if (commit_pair && widx[1] == 1'b1 && widx != 3'd4)
         commit[3:2] = 2'b11;
   end

   genvar gc;
   generate
      for (gc = 0; gc < OVUC_NCH; gc++)
      begin : g_chan
         always_comb
         begin
            pend_nxt[gc] = pend_r[gc];
            act_nxt[gc]  = act_r[gc];
            wait_nxt[gc] = wait_r[gc];
            if (i_wr && widx == 3'(gc))
            begin
               pend_nxt[gc].zc   = i_wdata[OVUC_BIT_ZC];
               pend_nxt[gc].mute = i_wdata[OVUC_BIT_MUTE];
               pend_nxt[gc].gain = clamp_gain(i_wdata[OVUC_VOL_W-1:0]);
            end
            if (commit[gc])
            begin
               if (!pend_nxt[gc].zc)
               begin
                  act_nxt[gc]  = pend_nxt[gc];
                  wait_nxt[gc] = 1'b0;
               end
               else
                  wait_nxt[gc] = 1'b1;
            end
            else if (wait_r[gc] && zc_edge[gc])
            begin
               // a later pending write before the crossing is taken in, since pend_r holds the latest value
               act_nxt[gc]  = pend_r[gc];
               wait_nxt[gc] = 1'b0;
            end
            else if (wait_r[gc] && !pend_r[gc].zc)
            begin
               act_nxt[gc]  = pend_r[gc];
               wait_nxt[gc] = 1'b0;
            end
         end

         always_ff @(posedge i_clk)
         begin
            if (i_sys_rst)
            begin
               pend_r[gc] <= OVUC_VOL_RST;
               act_r[gc]  <= OVUC_VOL_RST;
               wait_r[gc] <= 1'b0;
            end
            else if (i_ce)
            begin
               pend_r[gc] <= pend_nxt[gc];
               act_r[gc]  <= act_nxt[gc];
               wait_r[gc] <= wait_nxt[gc];
            end
         end
      end
   endgenerate

   // ---- plain register writes and reads ----
   always_comb
   begin
      pwr_nxt   = pwr_r;
      boost_nxt = boost_r;
      mode_nxt  = mode_r;
      aux1_nxt  = aux1_r;
      aux2_nxt  = aux2_r;
      rdata_nxt = 9'h000;
      if (i_wr)
      begin
         unique case (i_addr)
            OVUC_ADDR_PWR:      pwr_nxt   = i_wdata & 9'h07f;
            OVUC_ADDR_BOOST:    boost_nxt = i_wdata & 9'h003;
            OVUC_ADDR_SPK_MODE: mode_nxt  = i_wdata & 9'h001;
            OVUC_ADDR_AUX1:     aux1_nxt  = {i_wdata[8:6], clamp_gain(i_wdata[5:0])};
            OVUC_ADDR_AUX2:     aux2_nxt  = {i_wdata[8:6], clamp_gain(i_wdata[5:0])};
            default:            ;
         endcase
      end
      if (i_rd)
      begin
         unique case (i_addr)
            OVUC_ADDR_PWR:      rdata_nxt = pwr_r;
            OVUC_ADDR_BOOST:    rdata_nxt = boost_r;
            OVUC_ADDR_SPK_MODE: rdata_nxt = mode_r;
            OVUC_ADDR_AUX1:     rdata_nxt = aux1_r;
            OVUC_ADDR_AUX2:     rdata_nxt = aux2_r;
            OVUC_ADDR_HP_L:     rdata_nxt = {1'b0, pend_r[0]};
            OVUC_ADDR_HP_R:     rdata_nxt = {1'b0, pend_r[1]};
            OVUC_ADDR_SPK_L:    rdata_nxt = {1'b0, pend_r[2]};
            OVUC_ADDR_SPK_R:    rdata_nxt = {1'b0, pend_r[3]};
            OVUC_ADDR_STATUS:   rdata_nxt = {5'h00, wait_r};
            default:            rdata_nxt = 9'h000;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         pwr_r   <= OVUC_PWR_RST;
         boost_r <= OVUC_BOOST_RST;
         mode_r  <= OVUC_MODE_RST;
         aux1_r  <= OVUC_AUX_RST;
         aux2_r  <= OVUC_AUX_RST;
         rdata_r <= 9'h000;
      end
      else if (i_ce)
      begin
         pwr_r   <= pwr_nxt;
         boost_r <= boost_nxt;
         mode_r  <= mode_nxt;
         aux1_r  <= aux1_nxt;
         aux2_r  <= aux2_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign o_rdata = rdata_r;

   // ---- output stage controls ----
   // fields set one by one so a reordered struct cannot shift a bit
   always_comb
   begin
      // headphones have no source select
      // headphone boost tied low: that stage has no boost mode
      o_left_headphone_out.enable  = pwr_r[OVUC_PWR_HP_L];
      o_left_headphone_out.mute    = act_r[0].mute;
      o_left_headphone_out.gain    = act_r[0].gain;
      o_left_headphone_out.boost   = 1'b0;

      o_right_headphone_out.enable = pwr_r[OVUC_PWR_HP_R];
      o_right_headphone_out.mute   = act_r[1].mute;
      o_right_headphone_out.gain   = act_r[1].gain;
      o_right_headphone_out.boost  = 1'b0;

      o_left_speaker_out.enable    = pwr_r[OVUC_PWR_SPK_L];
      o_left_speaker_out.mute      = act_r[2].mute;
      o_left_speaker_out.gain      = act_r[2].gain;
      o_left_speaker_out.boost     = boost_r[OVUC_BOOST_SPK];

      o_right_speaker_out.enable   = pwr_r[OVUC_PWR_SPK_R];
      o_right_speaker_out.mute     = act_r[3].mute;
      o_right_speaker_out.gain     = act_r[3].gain;
      o_right_speaker_out.boost    = boost_r[OVUC_BOOST_SPK];

      // one boost bit serves both aux stages
      o_aux_output_one.enable      = pwr_r[OVUC_PWR_AUX1];
      o_aux_output_one.mute        = aux1_r[OVUC_BIT_MUTE];
      o_aux_output_one.gain        = aux1_r[5:0];
      o_aux_output_one.boost       = boost_r[OVUC_BOOST_AUX];

      o_aux_output_two.enable      = pwr_r[OVUC_PWR_AUX2];
      o_aux_output_two.mute        = aux2_r[OVUC_BIT_MUTE];
      o_aux_output_two.gain        = aux2_r[5:0];
      o_aux_output_two.boost       = boost_r[OVUC_BOOST_AUX];
   end

   assign o_aux_one_source = aux1_r[OVUC_AUX_SRC_LO+1:OVUC_AUX_SRC_LO];
   assign o_aux_two_source = aux2_r[OVUC_AUX_SRC_LO+1:OVUC_AUX_SRC_LO];
   // bias level is the host's choice per supply; logic only carries it out
   assign o_speaker_bias_select    = pwr_r[OVUC_PWR_BIAS];
   assign o_speaker_low_distortion = mode_r[OVUC_MODE_ULD];
endmodule
`default_nettype wire

// ==== ovuc_pkg.sv ====
// package: register offsets, field layouts and reset values for the output volume control block
`default_nettype none
package ovuc_pkg;
   // register indices (word addresses on the control port)
   localparam logic [6:0] OVUC_ADDR_PWR      = 7'h03;
   localparam logic [6:0] OVUC_ADDR_SPK_MODE = 7'h30;
   localparam logic [6:0] OVUC_ADDR_BOOST    = 7'h31;
   localparam logic [6:0] OVUC_ADDR_HP_L     = 7'h34;
   localparam logic [6:0] OVUC_ADDR_HP_R     = 7'h35;
   localparam logic [6:0] OVUC_ADDR_SPK_L    = 7'h36;
   localparam logic [6:0] OVUC_ADDR_SPK_R    = 7'h37;
   localparam logic [6:0] OVUC_ADDR_AUX2     = 7'h38;
   localparam logic [6:0] OVUC_ADDR_AUX1     = 7'h39;
   localparam logic [6:0] OVUC_ADDR_STATUS   = 7'h3a;

   // volume register fields: [5:0] gain, [6] mute, [7] zero-cross enable, [8] update
   localparam int OVUC_VOL_W      = 6;
   localparam int OVUC_BIT_MUTE   = 6;
   localparam int OVUC_BIT_ZC     = 7;
   localparam int OVUC_BIT_UPDATE = 8;
   // gain code 0 = -57 dB, step 3 dB, code 21 = +6 dB (top of range)
   localparam logic [5:0] OVUC_GAIN_MAX   = 6'h15;
   localparam logic [5:0] OVUC_GAIN_RST   = 6'h13;

   // power register fields
   localparam int OVUC_PWR_HP_L   = 0;
   localparam int OVUC_PWR_HP_R   = 1;
   localparam int OVUC_PWR_SPK_L  = 2;
   localparam int OVUC_PWR_SPK_R  = 3;
   localparam int OVUC_PWR_AUX1   = 4;
   localparam int OVUC_PWR_AUX2   = 5;
   localparam int OVUC_PWR_BIAS   = 6;
   localparam logic [8:0] OVUC_PWR_RST = 9'h000;

   // boost register: [0] speaker boost, [1] aux boost; both set after reset
   localparam int OVUC_BOOST_SPK  = 0;
   localparam int OVUC_BOOST_AUX  = 1;
   localparam logic [8:0] OVUC_BOOST_RST = 9'h003;

   // speaker mode register: [0] ultralow distortion mode
   localparam int OVUC_MODE_ULD   = 0;
   localparam logic [8:0] OVUC_MODE_RST = 9'h000;

   // aux register: [5:0] gain, [6] mute, [8:7] source select
   localparam int OVUC_AUX_SRC_LO = 7;
   localparam logic [8:0] OVUC_AUX_RST = 9'h040;

   localparam int OVUC_NCH = 4;   // 0 hp left, 1 hp right, 2 spk left, 3 spk right
   localparam logic [7:0] OVUC_VOL_RST = {2'b00, OVUC_GAIN_RST};

   // one channel's volume setting: zero-cross, mute, gain
   typedef struct packed
   {
      logic       zc;
      logic       mute;
      logic [5:0] gain;
   } ovuc_vol_t;

   // drive settings to one analog output stage
   typedef struct packed
   {
      logic       enable;
      logic       mute;
      logic [5:0] gain;
      logic       boost;
   } ovuc_drv_t;
endpackage
`default_nettype wire

// ==== ovuc_top_monitor.sv ====
// bound checker: register writes against driver settings
`default_nettype none
module ovuc_top_monitor
(
   // clock and reset
   input wire logic                i_clk,
   input wire logic                i_sys_rst,
   // register port
   input wire logic                i_ce,
   input wire logic [6:0]          i_addr,
   input wire logic [8:0]          i_wdata,
   input wire logic                i_wr,
   input wire logic                i_rd,
   input wire logic [8:0]          o_rdata,
   input wire logic [3:0]          i_zero_cross,
   // driver settings
   input wire ovuc_pkg::ovuc_drv_t o_left_headphone_out,
   input wire ovuc_pkg::ovuc_drv_t o_right_headphone_out,
   input wire ovuc_pkg::ovuc_drv_t o_left_speaker_out,
   input wire ovuc_pkg::ovuc_drv_t o_right_speaker_out,
   input wire ovuc_pkg::ovuc_drv_t o_aux_output_one,
   input wire ovuc_pkg::ovuc_drv_t o_aux_output_two,
   input wire logic [1:0]          o_aux_one_source,
   input wire logic                o_speaker_bias_select,
   input wire logic                o_speaker_low_distortion
);
   import ovuc_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   function automatic logic [5:0] clamp(input logic [5:0] g);
      return (g > OVUC_GAIN_MAX) ? OVUC_GAIN_MAX : g;
   endfunction
   sequence s_wr(logic [6:0] a);
      i_ce && i_wr && i_addr == a;
   endsequence
   sequence s_commit(logic [6:0] a);
      s_wr(a) ##0 i_wdata[OVUC_BIT_UPDATE] && !i_wdata[OVUC_BIT_ZC];
   endsequence
   // no crossing can land next cycle: synchroniser latency is three edges
   sequence s_quiet;
      i_zero_cross == 4'h0 && $past(i_zero_cross) == 4'h0 && $past(i_zero_cross, 2) == 4'h0;
   endsequence
   update_reads_zero_a: assert property (i_ce && i_rd && i_addr == OVUC_ADDR_HP_L |=> !o_rdata[8])
      else $error("update bit read back as one");
   pending_hold_a: assert property (s_wr(OVUC_ADDR_HP_L) ##0 !i_wdata[8] ##0 s_quiet
      |=> $stable(o_left_headphone_out)) else $error("pending write moved active setting");
   hp_commit_a: assert property (s_commit(OVUC_ADDR_HP_R) |=> o_right_headphone_out.gain ==
      clamp($past(i_wdata[5:0])) && o_right_headphone_out.mute == $past(i_wdata[6])) else $error("headphone commit lost");
   spk_commit_a: assert property (s_commit(OVUC_ADDR_SPK_R) |=> o_right_speaker_out.gain ==
      clamp($past(i_wdata[5:0])) && o_right_speaker_out.mute == $past(i_wdata[6])) else $error("speaker commit lost");
   zc_defer_a: assert property (s_wr(OVUC_ADDR_SPK_L) ##0 i_wdata[8] && i_wdata[7] ##0 s_quiet
      |=> $stable(o_left_speaker_out.gain)) else $error("gain changed without crossing");
   enable_map_a: assert property (s_wr(OVUC_ADDR_PWR) |=> {o_aux_output_two.enable, o_aux_output_one.enable,
      o_right_speaker_out.enable, o_left_speaker_out.enable, o_right_headphone_out.enable,
      o_left_headphone_out.enable, o_speaker_bias_select} == {$past(i_wdata[5:0]), $past(i_wdata[6])})
      else $error("enable bits misplaced");
   boost_reset_a: assert property ($fell(i_sys_rst) |-> o_left_speaker_out.boost && o_right_speaker_out.boost
      && o_aux_output_one.boost && o_aux_output_two.boost) else $error("boost clear after reset");
   boost_write_a: assert property (s_wr(OVUC_ADDR_BOOST) |=> o_right_speaker_out.boost == $past(i_wdata[0])
      && o_aux_output_one.boost == $past(i_wdata[1])) else $error("boost bits misplaced");
   uld_mode_a: assert property (s_wr(OVUC_ADDR_SPK_MODE) |=> o_speaker_low_distortion == $past(i_wdata[0]))
      else $error("distortion mode not stored");
   aux_ctrl_a: assert property (s_wr(OVUC_ADDR_AUX1) |=> o_aux_output_one.mute == $past(i_wdata[6])
      && o_aux_one_source == $past(i_wdata[8:7])) else $error("aux control not stored");
endmodule
bind ovuc_top ovuc_top_monitor i_mon
(
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .i_zero_cross(i_zero_cross), .o_left_headphone_out(o_left_headphone_out),
   .o_right_headphone_out(o_right_headphone_out), .o_left_speaker_out(o_left_speaker_out),
   .o_right_speaker_out(o_right_speaker_out), .o_aux_output_one(o_aux_output_one),
   .o_aux_output_two(o_aux_output_two), .o_aux_one_source(o_aux_one_source),
   .o_speaker_bias_select(o_speaker_bias_select), .o_speaker_low_distortion(o_speaker_low_distortion)
);
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the output volume control block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import ovuc_pkg::*;
   typedef struct packed { logic [6:0] a; logic [8:0] d; logic [8:0] q; } ovuc_row_t;
   logic       i_clk = 1'b0;
   logic       i_sys_rst = 1'b1;
   logic       i_ce = 1'b1;
   logic [6:0] i_addr = 7'h00;
   logic [8:0] i_wdata = 9'h000;
   logic       i_wr = 1'b0;
   logic       i_rd = 1'b0;
   logic [3:0] i_zero_cross = 4'h0;
   logic [8:0] o_rdata;
   ovuc_drv_t  hp_left, hp_right, spk_left, spk_right, aux1, aux2;
   logic [1:0] src1, src2;
   logic       bias, uld;
   int         bad_count = 0;
   int         check_count = 0;
   ovuc_row_t  rows [7] = '{'{OVUC_ADDR_PWR, 9'h07f, 9'h07f}, '{OVUC_ADDR_SPK_MODE, 9'h001, 9'h001},
      '{OVUC_ADDR_BOOST, 9'h000, 9'h000}, '{OVUC_ADDR_AUX1, 9'h185, 9'h185}, '{OVUC_ADDR_AUX2, 9'h0c2, 9'h0c2},
      '{OVUC_ADDR_SPK_R, 9'h10e, 9'h00e}, '{7'h10, 9'h1ff, 9'h000}};

   always #50 i_clk = ~i_clk;

   ovuc_top i_ovuc_top
   (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_zero_cross(i_zero_cross), .o_left_headphone_out(hp_left),
      .o_right_headphone_out(hp_right), .o_left_speaker_out(spk_left), .o_right_speaker_out(spk_right),
      .o_aux_output_one(aux1), .o_aux_output_two(aux2), .o_aux_one_source(src1), .o_aux_two_source(src2),
      .o_speaker_bias_select(bias), .o_speaker_low_distortion(uld)
   );

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // strobe is dropped one edge later, so a following call never meets it in the same step
   task automatic wr(input logic [6:0] a, input logic [8:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [6:0] a, input logic [8:0] exp);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, exp);
   endtask
   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      #100000;
      bad_count++;
      give_verdict();
   end

   initial
   begin
      repeat (4) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      foreach (rows[k])
      begin
         wr(rows[k].a, rows[k].d);
         rd(rows[k].a, rows[k].q);
      end
      chk(hp_left, {1'b1, 1'b0, 6'h13, 1'b0});
      chk(spk_left, {1'b1, 1'b0, 6'h13, 1'b0});
      chk(spk_right, {1'b1, 1'b0, 6'h0e, 1'b0});
      chk(aux1, {1'b1, 1'b0, 6'h05, 1'b0});
      chk(aux2, {1'b1, 1'b1, 6'h02, 1'b0});
      chk({3'h0, src1, src2, bias, uld}, 9'h037);
      wr(OVUC_ADDR_HP_L, 9'h03f);
      chk(hp_left, {1'b1, 1'b0, 6'h13, 1'b0});
      rd(OVUC_ADDR_HP_L, 9'h015);
      wr(OVUC_ADDR_HP_R, 9'h147);
      chk(hp_left, {1'b1, 1'b0, 6'h15, 1'b0});
      chk(hp_right, {1'b1, 1'b1, 6'h07, 1'b0});
      wr(OVUC_ADDR_SPK_L, 9'h18c);
      tick(4);
      chk(spk_left, {1'b1, 1'b0, 6'h13, 1'b0});
      rd(OVUC_ADDR_STATUS, 9'h004);
      @(posedge i_clk);
      i_zero_cross <= 4'h4;
      tick(2);
      chk(spk_left, {1'b1, 1'b0, 6'h13, 1'b0});
      tick(1);
      chk(spk_left, {1'b1, 1'b0, 6'h0c, 1'b0});
      @(posedge i_clk);
      i_zero_cross <= 4'h0;
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      #1;
      chk(spk_left, {1'b0, 1'b0, 6'h13, 1'b1});
      chk(aux1, {1'b0, 1'b1, 6'h00, 1'b1});
      wr(OVUC_ADDR_HP_L, 9'h10a);
      chk(hp_left, {1'b0, 1'b0, 6'h0a, 1'b0});
      chk(hp_right, {1'b0, 1'b0, 6'h13, 1'b0});
      // a write while the clock enable is low must leave the left headphone setting alone
      @(posedge i_clk);
      i_ce <= 1'b0;
      wr(OVUC_ADDR_PWR, 9'h001);
      @(posedge i_clk);
      i_ce <= 1'b1;
      #1;
      chk(hp_left, {1'b0, 1'b0, 6'h0a, 1'b0});
      give_verdict();
   end
endmodule
`default_nettype wire
